// ===== src/cim_bank.sv
// Purpose: charger event masks and monitor converter setup registers
// Assumes: register port is a simple byte write/read behind the host link
// Notes:   flags live outside; this bank gates their alerts
`default_nettype none
module cim_bank #(
   parameter int RES_W = 12,
   parameter int NCH   = 8
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               nrst,
   // register port
   input  wire logic               reg_wr,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic [7:0]              reg_rdata,
   // resets from charger core
   input  wire logic               reg_reset_cmd,
   input  wire logic               watchdog_expired,
   // charger events (one-cycle strobes) and conversion-done gate level
   input  wire logic               charge_status_chg,
   input  wire logic               supply_status_chg,
   input  wire logic               input_ovp_sleep_ev,
   input  wire logic               battery_fault_ev,
   input  wire logic               system_rail_fault_ev,
   input  wire logic               boost_fault_ev,
   input  wire logic               die_overheat_shutdown,
   input  wire logic               temp_zone_chg,
   input  wire logic               conv_done_ev,
   input  wire logic               conv_done_gate,
   // converter sample stream
   input  wire logic               sample_valid,
   input  wire logic [2:0]         sample_chan,
   input  wire logic [RES_W-1:0]   sample_data,
   // converter control to analog
   output logic                    conv_enable,
   output logic                    conv_one_shot,
   output logic [1:0]              conv_speed,
   output logic                    running_average_on,
   output logic                    average_seed_select,
   // event flags for the flag registers
   output logic [cim_pkg::CIM_NUM_EV-1:0] event_flags,
   // results
   output logic [NCH*RES_W-1:0]    results,
   // host alert (open drain, low while driving)
   output logic                    alert_o,
   output logic                    alert_oe
);
   import cim_pkg::*;

   logic [7:0] charge_event_gate_r;
   logic [7:0] flt_mask_r;
   logic [7:0] conv_ctl_r;
   logic [7:0] charge_event_gate_nxt;
   logic [7:0] flt_mask_nxt;
   logic [7:0] conv_ctl_nxt;
   logic [7:0] rdata_nxt;
   logic [CIM_NUM_EV-1:0] ev_raw;
   logic [CIM_NUM_EV-1:0] ev_gate;
   logic [CIM_NUM_EV-1:0] ev_fire;
   logic [CIM_NUM_EV-1:0] flags_nxt;
   logic       alert_pulse;
   logic       wr_chg;
   logic       wr_flt;
   logic       wr_conv;
   logic       charge_event_gate;
   logic       supply_event_gate;
   logic       input_ovp_sleep_gate;
   logic       battery_fault_gate;
   logic       system_rail_fault_gate;
   logic       boost_fault_gate;
   logic       thermal_shutdown_gate;
   logic       temp_zone_gate;
   logic       avg_restart;

   // address decode
   assign wr_chg  = reg_wr && (reg_addr == CIM_ADDR_CHG_GATES);
   assign wr_flt  = reg_wr && (reg_addr == CIM_ADDR_FLT_MASK);
   assign wr_conv = reg_wr && (reg_addr == CIM_ADDR_CONV_CTL);

   // reserved bits are never stored
   assign charge_event_gate_nxt = reg_reset_cmd ? CIM_CHG_GATES_RST :
                         wr_chg ? (reg_wdata & CIM_CHG_GATES_WR) :
                         charge_event_gate_r;
   assign flt_mask_nxt = reg_reset_cmd ? CIM_FLT_MASK_RST :
                         wr_flt ? (reg_wdata & CIM_FLT_MASK_WR) :
                         flt_mask_r;
   // watchdog clears only the enable bit
   assign conv_ctl_nxt =
      reg_reset_cmd ? CIM_CONV_CTL_RST :
      wr_conv ? ((reg_wdata & CIM_CONV_CTL_WR) &
                 ~({7'h00, watchdog_expired} << CIM_B_CONV_EN)) :
      (conv_ctl_r & ~({7'h00, watchdog_expired} << CIM_B_CONV_EN));

   always_comb begin
      unique case (reg_addr)
         CIM_ADDR_CHG_GATES: rdata_nxt = charge_event_gate_r;
         CIM_ADDR_FLT_MASK: rdata_nxt = flt_mask_r;
         CIM_ADDR_CONV_CTL: rdata_nxt = conv_ctl_r;
         default:           rdata_nxt = 8'h00;
      endcase
   end

   // named gate fields
   assign charge_event_gate      = charge_event_gate_r[CIM_B_CHARGE];
   assign supply_event_gate      = charge_event_gate_r[CIM_B_SUPPLY];
   assign input_ovp_sleep_gate   = flt_mask_r[CIM_B_INPUT_OVP];
   assign battery_fault_gate     = flt_mask_r[CIM_B_BATTERY];
   assign system_rail_fault_gate = flt_mask_r[CIM_B_SYSRAIL];
   assign boost_fault_gate       = flt_mask_r[CIM_B_BOOST];
   assign thermal_shutdown_gate  = flt_mask_r[CIM_B_THERMAL];
   assign temp_zone_gate         = flt_mask_r[CIM_B_TEMPZONE];

   assign ev_raw[CIM_EV_CHARGE]   = charge_status_chg;
   assign ev_raw[CIM_EV_SUPPLY]   = supply_status_chg;
   assign ev_raw[CIM_EV_INPUT]    = input_ovp_sleep_ev;
   assign ev_raw[CIM_EV_BATTERY]  = battery_fault_ev;
   assign ev_raw[CIM_EV_SYSRAIL]  = system_rail_fault_ev;
   assign ev_raw[CIM_EV_BOOST]    = boost_fault_ev;
   assign ev_raw[CIM_EV_THERMAL]  = die_overheat_shutdown;
   assign ev_raw[CIM_EV_TEMPZONE] = temp_zone_chg;
   assign ev_raw[CIM_EV_CONVDONE] = conv_done_ev;

   assign ev_gate[CIM_EV_CHARGE]   = charge_event_gate;
   assign ev_gate[CIM_EV_SUPPLY]   = supply_event_gate;
   assign ev_gate[CIM_EV_INPUT]    = input_ovp_sleep_gate;
   assign ev_gate[CIM_EV_BATTERY]  = battery_fault_gate;
   assign ev_gate[CIM_EV_SYSRAIL]  = system_rail_fault_gate;
   assign ev_gate[CIM_EV_BOOST]    = boost_fault_gate;
   assign ev_gate[CIM_EV_THERMAL]  = thermal_shutdown_gate;
   assign ev_gate[CIM_EV_TEMPZONE] = temp_zone_gate;
   // conversion done counts only in one-shot mode
   assign ev_gate[CIM_EV_CONVDONE] =
      conv_done_gate | ~conv_ctl_r[CIM_B_ONE_SHOT];

   assign ev_fire   = ev_raw & ~ev_gate;
   // flags set whatever the mask; here they are strobed outward
   assign flags_nxt = ev_raw;

   cim_alert_merge #(
      .N (CIM_NUM_EV)
   ) u_merge (
      .clk         (clk),
      .nrst        (nrst),
      .ev_fire     (ev_fire),
      .alert_pulse (alert_pulse)
   );

   // averaging restarts on a write that switches it off, or on register reset
   assign avg_restart = reg_reset_cmd |
                        (wr_conv & ~reg_wdata[CIM_B_AVG_ON]);

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic ch_valid;
         assign ch_valid = sample_valid && conv_ctl_r[CIM_B_CONV_EN] &&
                           (sample_chan == 3'(g));
         cim_conv_result #(
            .W (RES_W)
         ) u_res (
            .clk          (clk),
            .nrst         (nrst),
            .sample_valid (ch_valid),
            .sample_data  (sample_data),
            .speed        (conv_ctl_r[CIM_B_SPEED_LO+1:CIM_B_SPEED_LO]),
            .avg_on       (conv_ctl_r[CIM_B_AVG_ON]),
            .avg_seed_new (conv_ctl_r[CIM_B_AVG_SEED]),
            .avg_restart  (avg_restart),
            .result       (results[g*RES_W +: RES_W])
         );
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!nrst) begin
         charge_event_gate_r <= CIM_CHG_GATES_RST;
         flt_mask_r <= CIM_FLT_MASK_RST;
         conv_ctl_r <= CIM_CONV_CTL_RST;
      end else begin
         charge_event_gate_r <= charge_event_gate_nxt;
         flt_mask_r <= flt_mask_nxt;
         conv_ctl_r <= conv_ctl_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata   <= 8'h00;
         event_flags <= '0;
         alert_o     <= 1'b0;
         alert_oe    <= 1'b0;
      end else begin
         reg_rdata   <= rdata_nxt;
         event_flags <= flags_nxt;
         alert_o     <= 1'b0;
         alert_oe    <= alert_pulse;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         conv_enable         <= CIM_CONV_CTL_RST[CIM_B_CONV_EN];
         conv_one_shot       <= CIM_CONV_CTL_RST[CIM_B_ONE_SHOT];
         conv_speed          <=
            CIM_CONV_CTL_RST[CIM_B_SPEED_LO+1:CIM_B_SPEED_LO];
         running_average_on  <= CIM_CONV_CTL_RST[CIM_B_AVG_ON];
         average_seed_select <= CIM_CONV_CTL_RST[CIM_B_AVG_SEED];
      end else begin
         conv_enable         <= conv_ctl_nxt[CIM_B_CONV_EN];
         conv_one_shot       <= conv_ctl_nxt[CIM_B_ONE_SHOT];
         conv_speed          <=
            conv_ctl_nxt[CIM_B_SPEED_LO+1:CIM_B_SPEED_LO];
         running_average_on  <= conv_ctl_nxt[CIM_B_AVG_ON];
         average_seed_select <= conv_ctl_nxt[CIM_B_AVG_SEED];
      end
   end
endmodule
`default_nettype wire

// ===== src/cim_pkg.sv
// Purpose: shared constants for the charger mask and converter setup bank
// Assumes: 8-bit register file reached at byte addresses
// Notes:   none
`default_nettype none
package cim_pkg;
   localparam logic [7:0] CIM_ADDR_CHG_GATES = 8'h24;
   localparam logic [7:0] CIM_ADDR_FLT_MASK  = 8'h25;
   localparam logic [7:0] CIM_ADDR_CONV_CTL  = 8'h26;
   // writable bit sets
   localparam logic [7:0] CIM_CHG_GATES_WR   = 8'h09;
   localparam logic [7:0] CIM_FLT_MASK_WR    = 8'hF9;
   localparam logic [7:0] CIM_CONV_CTL_WR    = 8'hFC;
   // reset values
   localparam logic [7:0] CIM_CHG_GATES_RST  = 8'h00;
   localparam logic [7:0] CIM_FLT_MASK_RST   = 8'h00;
   localparam logic [7:0] CIM_CONV_CTL_RST   = 8'h30;
   // field positions
   localparam int CIM_B_CHARGE    = 3;
   localparam int CIM_B_SUPPLY    = 0;
   localparam int CIM_B_INPUT_OVP = 7;
   localparam int CIM_B_BATTERY   = 6;
   localparam int CIM_B_SYSRAIL   = 5;
   localparam int CIM_B_BOOST     = 4;
   localparam int CIM_B_THERMAL   = 3;
   localparam int CIM_B_TEMPZONE  = 0;
   localparam int CIM_B_CONV_EN   = 7;
   localparam int CIM_B_ONE_SHOT  = 6;
   localparam int CIM_B_SPEED_LO  = 4;
   localparam int CIM_B_AVG_ON    = 3;
   localparam int CIM_B_AVG_SEED  = 2;
   // event vector index
   localparam int CIM_EV_CHARGE   = 0;
   localparam int CIM_EV_SUPPLY   = 1;
   localparam int CIM_EV_INPUT    = 2;
   localparam int CIM_EV_BATTERY  = 3;
   localparam int CIM_EV_SYSRAIL  = 4;
   localparam int CIM_EV_BOOST    = 5;
   localparam int CIM_EV_THERMAL  = 6;
   localparam int CIM_EV_TEMPZONE = 7;
   localparam int CIM_EV_CONVDONE = 8;
   localparam int CIM_NUM_EV      = 9;
   localparam logic [4:0] CIM_RES_BITS_MAX = 5'h0C;
   localparam logic [11:0] CIM_RESULT_RST  = 12'h000;
endpackage
`default_nettype wire

// ===== src/cim_alert_merge.sv
// Purpose: merges gated event strobes into one alert pulse per pending source
// Assumes: event strobes are one-cycle pulses
// Notes:   coincident or close events queue and go out one by one
`default_nettype none
module cim_alert_merge #(
   parameter int N = 9
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // gated events
   input  wire logic [N-1:0] ev_fire,
   // alert pulse
   output logic              alert_pulse
);
   logic [N-1:0] pend_r;
   logic [N-1:0] pend_nxt;
   logic [N-1:0] low_one;
   logic         pulse_nxt;

   // pick one pending source per alert pulse, lowest index first
   assign low_one   = pend_r & (~pend_r + {{(N-1){1'b0}}, 1'b1});
   // a fresh event on the served bit is kept, not lost
   assign pend_nxt  = (pend_r & ~low_one) | ev_fire;
   // pulse only every other cycle so pulses stay separable
   assign pulse_nxt = (|pend_r) & ~alert_pulse;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pend_r      <= '0;
         alert_pulse <= 1'b0;
      end else begin
         pend_r      <= alert_pulse ? (pend_r | ev_fire) : pend_nxt;
         alert_pulse <= pulse_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== src/cim_conv_result.sv
// Purpose: one monitor result holder with resolution cut and running average
// Assumes: sample strobe marks a finished conversion
// Notes:   the result never clears except at power-on
`default_nettype none
module cim_conv_result #(
   parameter int W = 12
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // conversion input
   input  wire logic         sample_valid,
   input  wire logic [W-1:0] sample_data,
   input  wire logic [1:0]   speed,
   input  wire logic         avg_on,
   input  wire logic         avg_seed_new,
   input  wire logic         avg_restart,
   // result
   output logic [W-1:0]      result
);
   import cim_pkg::*;
   logic [W-1:0] cut;
   logic [W:0]   sum;
   logic         seeded_r;
   logic [W-1:0] res_nxt;

   // drop low bits for the chosen effective resolution
   assign cut = (sample_data >> speed) << speed;
   assign sum = {1'b0, result} + {1'b0, cut};
   // seed from held result or from fresh conversion
   assign res_nxt = !avg_on ? cut :
                    (!seeded_r && avg_seed_new) ? cut :
                    sum[W:1];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         result   <= W'(CIM_RESULT_RST);
         seeded_r <= 1'b0;
      end else begin
         if (avg_restart || !avg_on) begin
            seeded_r <= 1'b0;
         end else if (sample_valid) begin
            seeded_r <= 1'b1;
         end
         if (sample_valid) begin
            result <= res_nxt;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/cim_bank_asserts.sv
// Purpose: port checks for the mask and converter setup bank
// Assumes: writes land at the strobe edge, read data lags address one edge
// Notes:   mask registers are shadowed from the write port
`default_nettype none
module cim_bank_asserts import cim_pkg::*; #(
   parameter int RES_W = 12,
   parameter int NCH   = 8
) (
   // clock, reset and register port
   input wire logic clk, nrst, reg_wr, reg_reset_cmd, watchdog_expired,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   // event strobes and conversion-done gate level
   input wire logic charge_status_chg, supply_status_chg,
   input wire logic input_ovp_sleep_ev, battery_fault_ev,
   input wire logic system_rail_fault_ev, boost_fault_ev,
   input wire logic die_overheat_shutdown, temp_zone_chg,
   input wire logic conv_done_ev, conv_done_gate, sample_valid,
   // outputs
   input wire logic conv_enable, conv_one_shot, running_average_on,
   input wire logic average_seed_select, alert_o, alert_oe,
   input wire logic [1:0] conv_speed,
   input wire logic [CIM_NUM_EV-1:0] event_flags,
   input wire logic [NCH*RES_W-1:0] results
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] chg_r, flt_r, addr_r, wdata_r;
   logic [4:0] cnt_r;
   wire logic [8:0] ev = {conv_done_ev, temp_zone_chg, die_overheat_shutdown,
      boost_fault_ev, system_rail_fault_ev, battery_fault_ev,
      input_ovp_sleep_ev, supply_status_chg, charge_status_chg};
   wire logic [8:0] gate = {~conv_one_shot | conv_done_gate, flt_r[0],
      flt_r[3], flt_r[4], flt_r[5], flt_r[6], flt_r[7], chg_r[0], chg_r[3]};
   wire logic cause = |(ev & ~gate);
   wire logic [7:0] resv = (addr_r == CIM_ADDR_CHG_GATES) ? 8'hF6 :
      (addr_r == CIM_ADDR_FLT_MASK) ? 8'h06 :
      (addr_r == CIM_ADDR_CONV_CTL) ? 8'h03 : 8'hFF;
   wire logic dflt = conv_speed == 2'h3 && !conv_enable && !conv_one_shot
      && !running_average_on && !average_seed_select;
   always_ff @(posedge clk) begin
      addr_r <= reg_addr;
      wdata_r <= reg_wdata;
      if (!nrst || reg_reset_cmd) begin
         chg_r <= 8'h00;
         flt_r <= 8'h00;
      end else if (reg_wr && reg_addr == CIM_ADDR_CHG_GATES) begin
         chg_r <= reg_wdata;
      end else if (reg_wr && reg_addr == CIM_ADDR_FLT_MASK) begin
         flt_r <= reg_wdata;
      end
   end
   // cycles since the last unmasked event, saturating
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_r <= 5'h1F;
      end else begin
         cnt_r <= cause ? 5'h00 : cnt_r + {4'h0, cnt_r != 5'h1F};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   rst_defaults_a: assert property (
      disable iff (1'b0) !nrst |=> dflt && !alert_oe)
      else $error("setup outputs not at reset value");
   regrst_defaults_a: assert property (reg_reset_cmd |=> dflt)
      else $error("register reset left setup fields");
   wdog_clear_a: assert property (watchdog_expired |=> !conv_enable)
      else $error("watchdog did not clear converter enable");
   setup_write_a: assert property (
      reg_wr && reg_addr == CIM_ADDR_CONV_CTL && !reg_reset_cmd
      && !watchdog_expired |=> {conv_enable, conv_one_shot, conv_speed,
      running_average_on, average_seed_select} == wdata_r[7:2])
      else $error("setup outputs differ from written value");
   reserved_zero_a: assert property ((reg_rdata & resv) == 8'h00)
      else $error("reserved or unmapped bits read nonzero");
   unmasked_alert_a: assert property (
      cause |-> ##[2:12] alert_oe)
      else $error("unmasked event gave no alert");
   alert_cause_a: assert property (alert_oe |-> cnt_r < 5'h18)
      else $error("alert without unmasked event");
   alert_single_a: assert property (alert_oe |=> !alert_oe)
      else $error("alert pulse longer than one cycle");
   alert_low_a: assert property (alert_oe |-> !alert_o)
      else $error("alert line driven high");
   result_hold_a: assert property (
      !sample_valid ##1 !sample_valid |=> $stable(results))
      else $error("results changed without a sample");
   flag_copy_a: assert property (event_flags == $past(ev))
      else $error("event flags do not follow strobes");
   cover property (alert_oe);
   cover property (reg_wr && reg_addr == CIM_ADDR_CONV_CTL);
   cover property (watchdog_expired ##1 !conv_enable);
endmodule
bind cim_bank cim_bank_asserts #(.RES_W(RES_W), .NCH(NCH)) u_asserts (
   .clk, .nrst, .reg_wr, .reg_reset_cmd, .watchdog_expired, .reg_addr,
   .reg_wdata, .reg_rdata, .charge_status_chg, .supply_status_chg,
   .input_ovp_sleep_ev, .battery_fault_ev, .system_rail_fault_ev,
   .boost_fault_ev, .die_overheat_shutdown, .temp_zone_chg, .conv_done_ev,
   .conv_done_gate, .sample_valid, .conv_enable, .conv_one_shot,
   .running_average_on, .average_seed_select, .alert_o, .alert_oe,
   .conv_speed, .event_flags, .results);
`default_nettype wire

// ===== dv/cim_host.sv
// Purpose: host end of the alert line, counts alert pulses
// Assumes: open-drain line with a pull-up at the host
// Notes:   each high to low transition counts once
`default_nettype none
module cim_host (
   // clock
   input  wire logic   clk,
   // alert pin
   input  wire logic   alert_o,
   input  wire logic   alert_oe,
   // pulses seen
   output logic [11:0] pulses
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic int_line = alert_oe ? alert_o : 1'b1;
   logic      line_r = 1'b1;
   initial pulses = 12'h000;
   always @(posedge clk) begin
      if (line_r && !int_line) begin
         pulses <= pulses + 12'h001;
      end
      line_r <= int_line;
   end
endmodule
`default_nettype wire

// ===== dv/cim_bank_test.sv
// Purpose: self-checking bench for the mask and setup bank
// Assumes: one byte write per strobe, read data one edge after address, checked after two
// Notes:   alert pulses counted by the host model
`default_nettype none
module cim_bank_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rcmd = 1'b0, wdog = 1'b0;
   logic gate = 1'b0, sv = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic [8:0] ev = 9'h000;
   logic [11:0] sd = 12'h000;
   wire logic [7:0] rdata;
   wire logic [95:0] results;
   wire logic [8:0] flags;
   wire logic al_o, al_oe;
   wire logic [11:0] pulses;
   int errors = 0, compares = 0, cyc = 0;
   logic [15:0] mt [8] = '{16'h2408, 16'h2401, 16'h2580, 16'h2540,
                           16'h2520, 16'h2510, 16'h2508, 16'h2501};
   always #20 clk = ~clk;
   cim_bank uut (
      .clk(clk), .nrst(nrst), .reg_wr(wr_s), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .reg_reset_cmd(rcmd),
      .watchdog_expired(wdog), .charge_status_chg(ev[0]),
      .supply_status_chg(ev[1]), .input_ovp_sleep_ev(ev[2]),
      .battery_fault_ev(ev[3]), .system_rail_fault_ev(ev[4]),
      .boost_fault_ev(ev[5]), .die_overheat_shutdown(ev[6]),
      .temp_zone_chg(ev[7]), .conv_done_ev(ev[8]), .conv_done_gate(gate),
      .sample_valid(sv), .sample_chan(3'h0), .sample_data(sd),
      .conv_enable(), .conv_one_shot(), .conv_speed(),
      .running_average_on(), .average_seed_select(),
      .event_flags(flags), .results(results), .alert_o(al_o),
      .alert_oe(al_oe));
   cim_host host (.clk(clk), .alert_o(al_o), .alert_oe(al_oe),
      .pulses(pulses));
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [11:0] e, g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      #1 chk("rdata", {4'h0, e}, {4'h0, rdata});
   endtask
   // strobe events, then count alerts once the queue has drained
   task automatic fire(input logic [8:0] v, input int n);
      logic [11:0] c0;
      c0 = pulses;
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 9'h000;
      #1 chk("flags", {3'h0, v}, {3'h0, flags});
      repeat (30) @(posedge clk);
      #1 chk("alerts", c0 + 12'(n), pulses);
   endtask
   task automatic smp(input logic [11:0] d, e);
      @(posedge clk);
      sv <= 1'b1;
      sd <= d;
      @(posedge clk);
      sv <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("result", e, results[11:0]);
   endtask
   task automatic dflts();
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      rd(8'h26, 8'h30);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      dflts();
      rd(8'h27, 8'h00);
      chk("result", 12'h000, results[11:0]);
      wr(8'h24, 8'hFF);
      rd(8'h24, 8'h09);
      wr(8'h25, 8'hFF);
      rd(8'h25, 8'hF9);
      wr(8'h26, 8'hFF);
      rd(8'h26, 8'hFC);
      @(posedge clk);
      rcmd <= 1'b1;
      @(posedge clk);
      rcmd <= 1'b0;
      dflts();
      for (int i = 0; i < 8; i++) begin
         fire(9'(1 << i), 1);
         wr(mt[i][15:8], mt[i][7:0]);
         fire(9'(1 << i), 0);
         wr(mt[i][15:8], 8'h00);
      end
      fire(9'h0FF, 8);
      wr(8'h26, 8'h40);
      fire(9'h100, 1);
      @(posedge clk);
      gate <= 1'b1;
      fire(9'h100, 0);
      @(posedge clk);
      gate <= 1'b0;
      wr(8'h26, 8'h00);
      fire(9'h100, 0);
      for (int s = 0; s < 4; s++) begin
         wr(8'h26, 8'h80 | 8'(s << 4));
         smp(12'hFFF, 12'hFFF << s);
      end
      wr(8'h26, 8'h88);
      smp(12'h008, 12'h800);
      wr(8'h26, 8'hC8);
      @(posedge clk);
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      rd(8'h26, 8'h48);
      smp(12'h123, 12'h800);
      chk("result1", 12'h000, results[23:12]);
      finish_test();
   end
endmodule
`default_nettype wire
